// ===== verilog/wdt_pkg.sv
package wdt_pkg;

    // Register offsets
    localparam logic [7:0] UNIT_SEL_OFS   = 8'h52;
    localparam logic [7:0] VALUE_OFS      = 8'h53;
    localparam logic [7:0] CONFIG_OFS     = 8'h54;
    localparam logic [7:0] CONTROL_OFS    = 8'h55;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h60;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h61;

    // Reset values
    localparam logic [7:0] UNIT_SEL_RST   = 8'h00;
    localparam logic [7:0] VALUE_RST      = 8'h00;
    localparam logic [7:0] CONFIG_RST     = 8'h00;
    localparam logic [7:0] CONTROL_RST    = 8'h00;

    // Field positions
    localparam int UNIT_SECONDS_BIT = 7;
    localparam int GAME_EN_BIT      = 0;
    localparam int KBD_EN_BIT       = 1;
    localparam int MOUSE_EN_BIT     = 2;
    localparam int MAP_LSB          = 4;
    localparam int STATUS_BIT       = 0;
    localparam int FORCE_BIT        = 2;
    localparam int KBC_EN_BIT       = 3;

    // Mapping codes
    localparam logic [3:0] MAP_DISABLED = 4'h0;
    localparam logic [3:0] MAP_INVALID  = 4'h2;

    // Timing
    localparam int CLK_HZ          = 40_000_000;
    localparam int SECOND_S        = 1;
    localparam int SECONDS_PER_MIN = 60;
    localparam int SECOND_CYCLES   = CLK_HZ * SECOND_S;

    typedef struct packed {
        logic       unitSeconds;
        logic [7:0] value;
        logic       gameEn;
        logic       kbdEn;
        logic       mouseEn;
        logic [3:0] irqMap;
        logic       kbcEn;
    } watchdog_config_t;

    typedef struct packed {
        logic gameAccess;
        logic kbdIrq;
        logic mouseIrq;
    } restart_src_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_COUNT   = 3'b010,
        ST_EXPIRED = 3'b100
    } wdt_state_t;

endpackage

// ===== verilog/wdt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen
    import wdt_pkg::*;
#(
    parameter int SECOND_COUNT = SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic clkEn,
    // Control
    input  wire logic restart,
    input  wire logic unitSeconds,
    // Tick out
    output logic      unitTick
);
    logic [25:0] cycCnt_reg;
    logic [5:0]  secCnt_reg;
    logic        secTick;
    logic        minTick;

    assign secTick = (cycCnt_reg == 26'(SECOND_COUNT - 1));
    assign minTick = secTick && (secCnt_reg == 6'(SECONDS_PER_MIN - 1));
    assign unitTick = unitSeconds ? secTick : minTick; // R1

    // Restart realigns the prescaler so a full unit always elapses
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cycCnt_reg <= '0;
            secCnt_reg <= '0;
        end else if (clkEn) begin
            if (restart || secTick) begin // R15
                cycCnt_reg <= '0;
            end else begin
                cycCnt_reg <= cycCnt_reg + 26'd1;
            end
            if (restart || minTick) begin
                secCnt_reg <= '0;
            end else if (secTick) begin
                secCnt_reg <= secCnt_reg + 6'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/watchdog_timer_unit.sv
// Functional notes
// R1: Unit bit selects minutes or seconds
// R2: Timeout value counts binary units
// R3: Zero timeout value disables counting
// R4: Game port access restarts when enabled
// R5: Keyboard interrupt restarts when enabled
// R6: Mouse interrupt restarts when enabled
// R7: Mapping field selects interrupt line
// R8: Status bit set on timeout
// R9: Force bit makes timeout, self-clears
// R10: Enabled controller rising edge forces timeout
// R11: Controller edge pulse ORed with force
// R12: Software writes zero to reserved bits
// R13: Codes 3 to 15 map IRQ number; code 1 also maps to line 1 here, only codes 0 and 2 drive no line
// R14: Timeout sets status, asserts mapped line
// R15: Seconds and minutes ticks from clock
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit
    import wdt_pkg::*;
#(
    parameter int SECOND_COUNT = SECOND_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // Restart sources, same clock
    input  wire logic        gameAccess,
    input  wire logic        kbdIrq,
    input  wire logic        mouseIrq,
    // Keyboard controller line, asynchronous
    input  wire logic        kbcForceLine,
    // Interrupts
    output logic      [15:0] irqLines,
    output logic             irqOut
);
    watchdog_config_t     cfg;
    restart_src_t src;
    wdt_state_t   state_reg;
    wdt_state_t   state_next;

    logic [7:0] unitSel_reg;
    logic [7:0] value_reg;
    logic [7:0] config_reg;
    logic [7:0] control_reg;
    logic       irqStat_reg;
    logic       irqMask_reg;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] rdata_next;
    logic [2:0] kbcSync_reg;
    logic       kbcLevel_reg;
    logic [7:0] reloadVal;
    logic [7:0] cfgWrData;
    logic [7:0] unitWrData;

    logic wrUnit;
    logic wrValue;
    logic wrConfig;
    logic wrControl;
    logic wrIrqStat;
    logic wrIrqMask;
    logic swForce;
    logic kbcEdge;
    logic forceEvt;
    logic restartEvt;
    logic unitTick;
    logic expire;
    logic timeoutEvt;
    logic statusClr;
    logic mapValid;
    logic gameRestart;
    logic kbdRestart;
    logic mouseRestart;
    logic countTick;
    logic kbcHigh;
    logic irqStatClr;

    // Address is an argument so continuous assigns see it change
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // Address decode
    assign wrUnit     = regWr && hit(regAddr, UNIT_SEL_OFS);
    assign wrValue    = regWr && hit(regAddr, VALUE_OFS);
    assign wrConfig   = regWr && hit(regAddr, CONFIG_OFS);
    assign wrControl  = regWr && hit(regAddr, CONTROL_OFS);
    assign wrIrqStat  = regWr && hit(regAddr, IRQ_STAT_OFS);
    assign wrIrqMask  = regWr && hit(regAddr, IRQ_MASK_OFS);
    assign irqStatClr = wrIrqStat && regWdata[0];

    // Reserved bits are dropped on the way in
    assign unitWrData = {regWdata[UNIT_SECONDS_BIT], 7'h00}; // R1
    assign cfgWrData  = {regWdata[7:4], 1'b0, regWdata[2:0]};

    always_comb begin
        if (hit(regAddr, UNIT_SEL_OFS)) begin
            rdata_next = unitSel_reg;
        end else if (hit(regAddr, VALUE_OFS)) begin
            rdata_next = value_reg;
        end else if (hit(regAddr, CONFIG_OFS)) begin
            rdata_next = config_reg;
        end else if (hit(regAddr, CONTROL_OFS)) begin
            rdata_next = control_reg;
        end else if (hit(regAddr, IRQ_STAT_OFS)) begin
            rdata_next = {7'h00, irqStat_reg};
        end else if (hit(regAddr, IRQ_MASK_OFS)) begin
            rdata_next = {7'h00, irqMask_reg};
        end else begin
            rdata_next = 8'h00;
        end
    end

    assign cfg.unitSeconds = unitSel_reg[UNIT_SECONDS_BIT];
    assign cfg.value       = value_reg;
    assign cfg.gameEn      = config_reg[GAME_EN_BIT];
    assign cfg.kbdEn       = config_reg[KBD_EN_BIT];
    assign cfg.mouseEn     = config_reg[MOUSE_EN_BIT];
    assign cfg.irqMap      = config_reg[MAP_LSB +: 4];
    assign cfg.kbcEn       = control_reg[KBC_EN_BIT];

    assign src.gameAccess = gameAccess;
    assign src.kbdIrq     = kbdIrq;
    assign src.mouseIrq   = mouseIrq;

    // Restart qualification
    assign gameRestart  = cfg.gameEn && src.gameAccess; // R4
    assign kbdRestart   = cfg.kbdEn && src.kbdIrq; // R5
    assign mouseRestart = cfg.mouseEn && src.mouseIrq; // R6
    assign restartEvt   = gameRestart || kbdRestart || mouseRestart
                       || wrValue; // R14

    // New value takes effect in the cycle it is written
    assign reloadVal = wrValue ? regWdata : cfg.value; // R14

    // A rise counts only once both late stages agree
    assign kbcHigh  = kbcSync_reg[2] && kbcSync_reg[1];
    assign swForce  = wrControl && regWdata[FORCE_BIT]; // R9
    assign kbcEdge  = cfg.kbcEn && kbcHigh && !kbcLevel_reg; // R10
    assign forceEvt = swForce || kbcEdge; // R11

    wdt_tick_gen #(
        .SECOND_COUNT (SECOND_COUNT)
    ) tickGen (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .clkEn       (clkEn),
        .restart     (restartEvt),
        .unitSeconds (cfg.unitSeconds),
        .unitTick    (unitTick)
    );

    // Count down in whole units; value 1 expires after one unit
    assign countTick  = (state_reg == ST_COUNT) && unitTick;
    assign expire     = countTick && (count_reg == 8'h01) && !restartEvt; // R2
    assign timeoutEvt = expire || forceEvt; // R14

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cfg.value != 8'h00) begin // R3
                    state_next = ST_COUNT;
                    count_next = cfg.value;
                end
            end
            ST_COUNT: begin
                if (cfg.value == 8'h00) begin // R3
                    state_next = ST_IDLE;
                end else if (restartEvt) begin
                    count_next = reloadVal;
                end else if (expire) begin
                    state_next = ST_EXPIRED;
                end else if (unitTick) begin
                    count_next = count_reg - 8'h01; // R2
                end
            end
            ST_EXPIRED: begin
                // Stays expired until any restart event reloads it or a zero value disables
                if (cfg.value == 8'h00) begin
                    state_next = ST_IDLE;
                end else if (restartEvt) begin
                    state_next = ST_COUNT;
                    count_next = reloadVal;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Status written to 0 clears it, but a same-cycle timeout wins
    assign statusClr = wrControl && !regWdata[STATUS_BIT];

    // Invalid code 0010 treated as disabled
    assign mapValid = (cfg.irqMap != MAP_DISABLED)
                   && (cfg.irqMap != MAP_INVALID); // R7

    // Line follows status, so clearing status drops it
    always_comb begin
        irqLines = 16'h0000;
        if (mapValid && control_reg[STATUS_BIT]) begin
            irqLines[cfg.irqMap] = 1'b1; // R13
        end
    end

    assign irqOut = irqStat_reg && irqMask_reg;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            count_reg <= 8'h00;
        end else if (clkEn) begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            unitSel_reg <= UNIT_SEL_RST;
            value_reg   <= VALUE_RST;
            config_reg  <= CONFIG_RST;
            irqMask_reg <= 1'b0;
        end else if (clkEn) begin
            if (wrUnit) begin
                unitSel_reg <= unitWrData; // R1
            end
            if (wrValue) begin
                value_reg <= regWdata;
            end
            if (wrConfig) begin
                config_reg <= cfgWrData;
            end
            if (wrIrqMask) begin
                irqMask_reg <= regWdata[0];
            end
        end
    end

    // Force bit never stored, so it reads back as zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            control_reg <= CONTROL_RST;
        end else if (clkEn) begin
            if (wrControl) begin
                // Reserved upper bits held at zero whatever is written
                control_reg[KBC_EN_BIT] <= regWdata[KBC_EN_BIT]; // R10
            end
            if (timeoutEvt) begin
                control_reg[STATUS_BIT] <= 1'b1; // R8
            end else if (statusClr) begin
                control_reg[STATUS_BIT] <= 1'b0;
            end else if (wrControl) begin
                control_reg[STATUS_BIT] <= regWdata[STATUS_BIT];
            end
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irqStat_reg <= 1'b0;
        end else if (clkEn) begin
            if (timeoutEvt) begin
                irqStat_reg <= 1'b1; // R14
            end else if (irqStatClr) begin
                irqStat_reg <= 1'b0;
            end
        end
    end

    // Three-stage sync; edge uses stages two and three only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            kbcSync_reg  <= 3'b000;
            kbcLevel_reg <= 1'b0;
        end else if (clkEn) begin
            kbcSync_reg <= {kbcSync_reg[1:0], kbcForceLine};
            if (kbcSync_reg[2] == kbcSync_reg[1]) begin
                kbcLevel_reg <= kbcSync_reg[2]; // R11
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= 8'h00;
        end else if (clkEn) begin
            regRdata <= regRd ? rdata_next : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== test/watchdog_timer_unit_props.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_props
    import wdt_pkg::*;
#(
    parameter int SECOND_COUNT = 10
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        clkEn,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [7:0]  regRdata,
    // Events and interrupts
    input wire logic        gameAccess,
    input wire logic        kbdIrq,
    input wire logic        mouseIrq,
    input wire logic        kbcForceLine,
    input wire logic [15:0] irqLines,
    input wire logic        irqOut
);
    logic [3:0] mapReg;
    logic       kbcEnReg;
    wire        wrEn  = regWr && clkEn;
    wire        mapOk = mapReg != MAP_DISABLED && mapReg != MAP_INVALID;

    // Shadow of the map and edge enable, so lines can be predicted
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mapReg   <= MAP_DISABLED;
            kbcEnReg <= 1'b0;
        end else if (wrEn && regAddr == CONFIG_OFS) begin
            mapReg   <= regWdata[7:4];
        end else if (wrEn && regAddr == CONTROL_OFS) begin
            kbcEnReg <= regWdata[KBC_EN_BIT];
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence rdAt(a);
        regRd && regAddr == a;
    endsequence
    sequence forceWr;
        wrEn && regAddr == CONTROL_OFS && regWdata[FORCE_BIT];
    endsequence

    chk_rd_idle: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_unit_rsvd: assert property (
        rdAt(UNIT_SEL_OFS) |=> regRdata[6:0] == 7'h00)
        else $error("unit select reserved bits set");
    chk_value_rdback: assert property (
        wrEn && regAddr == VALUE_OFS ##2 rdAt(VALUE_OFS)
        |=> regRdata == $past(regWdata, 3))
        else $error("timeout value readback wrong");
    chk_ctrl_rsvd: assert property (
        rdAt(CONTROL_OFS) |=> (regRdata & 8'hF6) == 8'h00)
        else $error("control force or reserved bits read set");
    chk_irq_onehot: assert property (
        $onehot0(irqLines) && !irqLines[0] && !irqLines[2])
        else $error("irq lines not a single valid line");
    chk_map_off: assert property (!mapOk |-> irqLines == 16'h0000)
        else $error("irq line driven with mapping off");
    chk_force_irq: assert property (
        forceWr ##0 mapOk |=> irqLines[mapReg])
        else $error("force did not raise the mapped line");
    chk_force_stat: assert property (
        forceWr ##2 rdAt(CONTROL_OFS) |=> regRdata[STATUS_BIT])
        else $error("status not set after force");
    chk_kbc_edge: assert property (
        $rose(kbcForceLine) && kbcEnReg && mapOk
        |-> ##[1:6] irqLines[mapReg])
        else $error("controller edge did not force a timeout");
    chk_kbc_off: assert property (
        $rose(kbcForceLine) && !kbcEnReg && irqLines == 16'h0000
        |=> irqLines == 16'h0000 [*6])
        else $error("disabled controller edge forced a timeout");
endmodule

bind watchdog_timer_unit watchdog_timer_unit_props #(
    .SECOND_COUNT(SECOND_COUNT)) props (
    .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .gameAccess(gameAccess),
    .kbdIrq(kbdIrq), .mouseIrq(mouseIrq), .kbcForceLine(kbcForceLine),
    .irqLines(irqLines), .irqOut(irqOut));
`default_nettype wire

// ===== test/watchdog_timer_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_unit_bench
    import wdt_pkg::*;
;
    localparam int SEC = 10;
    logic        sys_clk, resetn, regWr, regRd, rdSeen, irqOut, clkEn;
    logic        gameAccess, kbdIrq, mouseIrq, kbcForceLine;
    logic [7:0]  regAddr, regWdata, regRdata, en;
    logic [15:0] irqLines, lfsr;
    logic [7:0]  expQ[$];
    string       nameQ[$];
    int          fail_count, n_checks;
    logic [7:0]  offs[7] = '{UNIT_SEL_OFS, VALUE_OFS, CONFIG_OFS,
        CONTROL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS, 8'h70};

    watchdog_timer_unit #(.SECOND_COUNT(SEC)) dut (
        .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .gameAccess(gameAccess),
        .kbdIrq(kbdIrq), .mouseIrq(mouseIrq), .kbcForceLine(kbcForceLine),
        .irqLines(irqLines), .irqOut(irqOut));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    function automatic logic [15:0] lfsrNext(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic chk3(string nm, logic e);
        cmp(nm, {15'h0, e}, {15'h0, irqLines[3]});
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
        expQ.push_back(e);
        nameQ.push_back(nm);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
    endtask
    task automatic pulse(int k);
        @(posedge sys_clk);
        {mouseIrq, kbdIrq, gameAccess} <= 3'(1 << k);
        @(posedge sys_clk);
        {mouseIrq, kbdIrq, gameAccess} <= 3'h0;
    endtask
    task automatic idle(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Bounded wait on line 3; a run-out ends the test
    task automatic waitIrq(int lim);
        for (int i = 0; i < lim && irqLines[3] !== 1'b1; i++) idle(1);
        chk3("irqWait", 1'b1);
        if (irqLines[3] !== 1'b1) summarize();
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) rdSeen <= regRd;
    always @(negedge sys_clk) begin
        if (rdSeen === 1'b1)
            cmp(nameQ.pop_front(), {8'h00, expQ.pop_front()},
                {8'h00, regRdata});
    end

    initial begin
        {regWr, regRd, gameAccess, kbdIrq, mouseIrq, kbcForceLine} = 6'h00;
        clkEn    = 1'b1;
        regAddr  = 8'h00;
        regWdata = 8'h00;
        resetn   = 1'b0;
        lfsr     = 16'h7CC3;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        foreach (offs[i]) rd(offs[i], 8'h00, "resetVal");
        repeat (4) begin
            lfsr = lfsrNext(lfsr);
            wr(UNIT_SEL_OFS, lfsr[7:0]);
            rd(UNIT_SEL_OFS, {lfsr[7], 7'h00}, "unitSel");
            wr(CONFIG_OFS, lfsr[15:8]);
            rd(CONFIG_OFS, lfsr[15:8] & 8'hF7, "config");
            wr(VALUE_OFS, lfsr[7:0]);
            rd(VALUE_OFS, lfsr[7:0], "value");
        end
        wr(VALUE_OFS, 8'h00);
        wr(CONTROL_OFS, 8'h00);
        wr(IRQ_STAT_OFS, 8'h01);
        wr(CONTROL_OFS, 8'h04);
        rd(IRQ_STAT_OFS, 8'h01, "irqStat");
        idle(1);
        cmp("irqMasked", 16'h0, {15'h0, irqOut});
        wr(IRQ_STAT_OFS, 8'h01);
        wr(IRQ_MASK_OFS, 8'h01);
        for (int c = 0; c < 16; c++) begin
            wr(CONFIG_OFS, {c[3:0], 4'h0});
            wr(CONTROL_OFS, 8'h04);
            idle(1);
            cmp("irqLines", (c == 0 || c == 2) ? 16'h0 : 16'h1 << c,
                irqLines);
            cmp("irqOut", 16'h1, {15'h0, irqOut});
            rd(CONTROL_OFS, 8'h01, "status");
            wr(CONTROL_OFS, 8'h00);
            wr(IRQ_STAT_OFS, 8'h01);
            idle(1);
            cmp("cleared", 16'h0, {14'h0, |irqLines, irqOut});
        end
        wr(UNIT_SEL_OFS, 8'h80);
        for (int s = 0; s < 6; s++) begin
            en = 8'((s % 2) << (s / 2));
            wr(CONFIG_OFS, 8'h30 | en);
            wr(VALUE_OFS, 8'h02);
            wr(CONTROL_OFS, 8'h00);
            idle(12);
            pulse(s / 2);
            idle(10);
            chk3("restart", ~en[s / 2]);
            waitIrq(40);
        end
        wr(VALUE_OFS, 8'hFF);
        wr(CONTROL_OFS, 8'h00);
        idle(2530);
        chk3("fullCount", 1'b0);
        waitIrq(40);
        wr(UNIT_SEL_OFS, 8'h00);
        wr(VALUE_OFS, 8'h01);
        wr(CONTROL_OFS, 8'h00);
        idle(585);
        chk3("minute", 1'b0);
        waitIrq(40);
        wr(VALUE_OFS, 8'h00);
        wr(CONTROL_OFS, 8'h00);
        idle(300);
        chk3("disabled", 1'b0);
        wr(CONTROL_OFS, 8'h08);
        @(posedge sys_clk);
        kbcForceLine <= 1'b1;
        waitIrq(8);
        // Line stays high: a level must not force again
        wr(CONTROL_OFS, 8'h08);
        idle(10);
        chk3("kbcLevel", 1'b0);
        rd(CONTROL_OFS, 8'h08, "ctrl");
        @(posedge sys_clk);
        kbcForceLine <= 1'b0;
        wr(CONTROL_OFS, 8'h00);
        @(posedge sys_clk);
        kbcForceLine <= 1'b1;
        idle(10);
        chk3("kbcOff", 1'b0);
        // Clock enable low must hold the count where it is
        wr(UNIT_SEL_OFS, 8'h80);
        wr(VALUE_OFS, 8'h01);
        wr(CONTROL_OFS, 8'h00);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        idle(30);
        chk3("frozen", 1'b0);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        waitIrq(40);
        summarize();
    end
endmodule
`default_nettype wire
